/* rtl/ppcs_pkg.sv */
// Constants and types shared by the press cycle sequencer
package ppcs_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20000000;        // System clock rate
    localparam int MS_PER_S = 1000;          // Milliseconds per second
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S; // Cycles in one tick
    localparam int OCC_MIN_MS = 100;         // Least hold of a valid break
    localparam int RELEASE_MAX_MS = 200;     // Latest re-close after last break
    localparam logic [6:0] OCC_MIN = 7'(OCC_MIN_MS); // Hold count at timer width

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;     // Mode and option bits
    localparam logic [7:0] ADDR_WIN_MS = 8'h04;   // Window limit in ms
    localparam logic [7:0] ADDR_STATUS = 8'h08;   // Live sequencer state
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C; // Sticky events, write one to clear
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10; // Event enables

    // ------------------------------------------------------------
    // Control fields and reset values
    // ------------------------------------------------------------
    localparam int CTRL_DOUBLE = 0;          // Two breaks instead of one
    localparam int CTRL_WIN_EN = 1;          // Window supervision on
    localparam int CTRL_SMODE_LO = 2;        // Start sequence, two bits
    localparam int CTRL_START_EN = 4;        // Start input defined
    localparam int CTRL_OVR_EN = 5;          // Overrun contact monitored
    localparam int CTRL_W = 6;               // Control width
    localparam logic [5:0] CTRL_RST = 6'h00; // Single break, standard start
    localparam logic [15:0] WIN_MS_RST = 16'h03E8; // Default window limit
    localparam int IRQ_W = 5;                // Event count
    localparam logic [4:0] IRQ_RST = 5'h00;  // Events clear after reset

    // Event bit positions
    localparam int EV_RELEASE = 0;
    localparam int EV_TDC_STOP = 1;
    localparam int EV_CUT = 2;
    localparam int EV_EXPIRED = 3;
    localparam int EV_OVERRUN = 4;

    // Start sequence encodings
    localparam logic [1:0] SMODE_STD = 2'h0;      // Breaks, then reset button
    localparam logic [1:0] SMODE_RST_FIRST = 2'h1; // Reset button, then breaks
    localparam logic [1:0] SMODE_NO_ILK = 2'h2;   // Breaks only, external interlock

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_APP, ST_ARM, ST_RUN, ST_COUNT} ppcs_state_e;
    typedef enum logic [1:0] {PH_STOP, PH_DOWN, PH_UP} ppcs_phase_e;
endpackage

/* rtl/ppcs_sync.sv */
// Two-stage synchroniser for the contact, sensor and button inputs
`timescale 1ns/1ps
`default_nettype none
module ppcs_sync #(
    parameter int WIDTH = 6
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // First stage, read only by the second
    logic [WIDTH-1:0] meta_reg;

    // Both stages clear to zero, the safe outputs-off view
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // ppcs_sync
`default_nettype wire

/* rtl/ppcs_seq.sv */
// Presence-sensing press cycle sequencer with register port
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Decode down, up, stopped; down is dangerous
// - Stopped is safe only with overrun contact high
// - Accept non-overlapping top and bottom windows
// - Top reached: outputs off within response time
// - Valid break lasts at least 100 ms
// - Outputs re-close within 200 ms of last break
// - Hold at top until breaks done, auto release
// - Single mode: one break and leave, release
// - Break during downward stroke cuts outputs
// - Double mode: two breaks inside window
// - Window supervision limits time for breaks
// - Window timer starts at rest at top
// - Window expiry: outputs off, restart per mode
// - Start input needed only before first cycle
// - Three start sequences: standard, reset-first, none
module ppcs_seq #(
    parameter int CYC_PER_MS = ppcs_pkg::CYC_PER_MS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Machine contacts and sensor
    input wire logic tdc_contact,
    input wire logic bdc_contact,
    input wire logic overrun_contact,
    input wire logic protective_field_sensor,
    // Operator buttons
    input wire logic reset_button,
    input wire logic start_button,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Outputs
    output logic safety_switch_output,
    output logic irq
);
    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    logic [5:0] pins_s;     // Synchronised inputs
    logic [5:0] pins_d_reg; // One cycle older copy for edges
    logic tdc_s, bdc_s, ovr_s, field_clear_s, rbtn_s, sbtn_s;

    ppcs_sync #(.WIDTH(6)) u_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in({start_button, reset_button, protective_field_sensor,
                   overrun_contact, bdc_contact, tdc_contact}),
        .sync_out(pins_s)
    );

    assign {sbtn_s, rbtn_s, field_clear_s, ovr_s, bdc_s, tdc_s} = pins_s;

    // Edge history of the synchronised inputs
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pins_d_reg <= 6'h00;
        end else begin
            pins_d_reg <= pins_s;
        end
    end

    logic tdc_rise, rbtn_rise, sbtn_rise;
    assign tdc_rise = tdc_s && !pins_d_reg[0];
    assign rbtn_rise = rbtn_s && !pins_d_reg[4];
    assign sbtn_rise = sbtn_s && !pins_d_reg[5];

    // ------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------
    logic [14:0] div_reg; // Cycle count inside one ms
    logic ms_tick;
    assign ms_tick = (div_reg == 15'(CYC_PER_MS - 1));

    // Free-running divider, all ms timers share it
    always_ff @(posedge sys_clk) begin
        if (reset || ms_tick) begin
            div_reg <= 15'h0000;
        end else begin
            div_reg <= div_reg + 15'h0001;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [5:0] ctrl_reg;              // Mode and option bits
    logic [15:0] win_ms_reg;           // Window limit in ms
    logic [4:0] irq_stat_reg;          // Sticky events
    logic [4:0] irq_mask_reg;          // Event enables
    logic [4:0] ev;                    // Event pulses this cycle
    logic wr_ctrl, wr_win, wr_stat, wr_mask;

    assign wr_ctrl = reg_wr && (reg_addr == ppcs_pkg::ADDR_CTRL);
    assign wr_win = reg_wr && (reg_addr == ppcs_pkg::ADDR_WIN_MS);
    assign wr_stat = reg_wr && (reg_addr == ppcs_pkg::ADDR_IRQ_STAT);
    assign wr_mask = reg_wr && (reg_addr == ppcs_pkg::ADDR_IRQ_MASK);

    logic dbl, win_en, start_en, ovr_en;
    logic [1:0] smode;
    assign dbl = ctrl_reg[ppcs_pkg::CTRL_DOUBLE];
    assign win_en = ctrl_reg[ppcs_pkg::CTRL_WIN_EN];
    assign smode = ctrl_reg[ppcs_pkg::CTRL_SMODE_LO +: 2];
    assign start_en = ctrl_reg[ppcs_pkg::CTRL_START_EN];
    assign ovr_en = ctrl_reg[ppcs_pkg::CTRL_OVR_EN];

    // Configuration writes; changing mode mid-cycle takes effect at once
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_reg <= ppcs_pkg::CTRL_RST;
            win_ms_reg <= ppcs_pkg::WIN_MS_RST;
            irq_mask_reg <= ppcs_pkg::IRQ_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= reg_wdata[ppcs_pkg::CTRL_W-1:0];
            end
            if (wr_win) begin
                win_ms_reg <= reg_wdata[15:0];
            end
            if (wr_mask) begin
                irq_mask_reg <= reg_wdata[ppcs_pkg::IRQ_W-1:0];
            end
        end
    end

    // Sticky events; a new event beats a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_stat_reg <= ppcs_pkg::IRQ_RST;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~(wr_stat ? reg_wdata[4:0] : 5'h00)) | ev;
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    ppcs_pkg::ppcs_state_e state_reg, state_next;
    ppcs_pkg::ppcs_phase_e phase;
    logic [1:0] count_reg;   // Valid breaks taken
    logic [6:0] occ_ms_reg;  // Length of current break, saturating
    logic [15:0] win_cnt_reg; // Time spent at rest at top
    logic rst_seen_reg;      // Reset pressed in reset-first start
    logic first_done_reg;    // Start command already given
    logic occupied, intr_done, cnt_done, ovr_bad, win_exp, app_ok;
    logic [1:0] need;

    assign occupied = !field_clear_s;
    assign need = dbl ? 2'h2 : 2'h1;
    // At or past need, so lowering the mode mid-wait cannot deadlock
    assign cnt_done = (count_reg >= need);

    // Phase from contacts; bottom contact only read while moving,
    // so overlapping or separate windows both decode the same way
    always_comb begin
        if (!safety_switch_output) begin
            phase = ppcs_pkg::PH_STOP;
        end else if (bdc_s) begin
            phase = ppcs_pkg::PH_UP;
        end else begin
            phase = ppcs_pkg::PH_DOWN;
        end
    end

    // A stop is unsafe when the overrun contact has dropped
    assign ovr_bad = ovr_en && !ovr_s && (phase == ppcs_pkg::PH_STOP);

    // Break completes when the field clears after the least hold
    assign intr_done = field_clear_s && (occ_ms_reg == ppcs_pkg::OCC_MIN);

    assign win_exp = win_en && (win_cnt_reg >= win_ms_reg);

    // Application start condition per start sequence
    always_comb begin
        case (smode)
            ppcs_pkg::SMODE_STD: begin
                app_ok = cnt_done && rbtn_rise;
            end
            ppcs_pkg::SMODE_RST_FIRST: begin
                app_ok = rst_seen_reg && cnt_done;
            end
            ppcs_pkg::SMODE_NO_ILK: begin
                app_ok = cnt_done;
            end
            default: begin
                app_ok = 1'b0;
            end
        endcase
    end

    // Next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ppcs_pkg::ST_RUN: begin
                if (occupied && (phase == ppcs_pkg::PH_DOWN)) begin
                    state_next = ppcs_pkg::ST_APP;
                end else if (tdc_rise) begin
                    state_next = ppcs_pkg::ST_COUNT;
                end
            end
            ppcs_pkg::ST_COUNT: begin
                if (ovr_bad) begin
                    state_next = ppcs_pkg::ST_APP;
                end else if (intr_done && (count_reg >= need - 2'h1)) begin
                    state_next = ppcs_pkg::ST_RUN;
                end else if (win_exp) begin
                    state_next = ppcs_pkg::ST_APP;
                end
            end
            ppcs_pkg::ST_APP: begin
                if (!ovr_bad && app_ok) begin
                    // Start command only before the first cycle
                    state_next = (start_en && !first_done_reg) ?
                                 ppcs_pkg::ST_ARM : ppcs_pkg::ST_RUN;
                end
            end
            ppcs_pkg::ST_ARM: begin
                if (ovr_bad) begin
                    state_next = ppcs_pkg::ST_APP;
                end else if (sbtn_rise) begin
                    state_next = ppcs_pkg::ST_RUN;
                end
            end
            default: begin
                state_next = ppcs_pkg::ST_APP;
            end
        endcase
    end

    // State register; reset leaves the press waiting, outputs off
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg <= ppcs_pkg::ST_APP;
        end else begin
            state_reg <= state_next;
        end
    end

    // Output switch, registered from the next state
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            safety_switch_output <= 1'b0;
        end else begin
            safety_switch_output <= (state_next == ppcs_pkg::ST_RUN);
        end
    end

    // Events for the interrupt status
    always_comb begin
        ev = 5'h00;
        ev[ppcs_pkg::EV_RELEASE] = (state_reg != ppcs_pkg::ST_RUN) &&
                                   (state_next == ppcs_pkg::ST_RUN);
        ev[ppcs_pkg::EV_TDC_STOP] = (state_reg == ppcs_pkg::ST_RUN) &&
                                    (state_next == ppcs_pkg::ST_COUNT);
        ev[ppcs_pkg::EV_CUT] = (state_reg == ppcs_pkg::ST_RUN) &&
                               (state_next == ppcs_pkg::ST_APP);
        ev[ppcs_pkg::EV_EXPIRED] = (state_reg == ppcs_pkg::ST_COUNT) && !ovr_bad &&
                                   (state_next == ppcs_pkg::ST_APP);
        ev[ppcs_pkg::EV_OVERRUN] = ovr_bad && (state_reg == ppcs_pkg::ST_COUNT);
    end

    // ------------------------------------------------------------
    // Timers and counters
    // ------------------------------------------------------------
    // Break length in ms; a clear field restarts it
    always_ff @(posedge sys_clk) begin
        if (reset || field_clear_s) begin
            occ_ms_reg <= 7'h00;
        end else if (ms_tick && (occ_ms_reg != ppcs_pkg::OCC_MIN)) begin
            occ_ms_reg <= occ_ms_reg + 7'h01;
        end
    end

    // Break count; cleared at each top stop and each fall to waiting
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count_reg <= 2'h0;
        end else if ((state_next != state_reg) && (state_next != ppcs_pkg::ST_RUN)) begin
            count_reg <= 2'h0;
        end else if (ovr_bad) begin
            count_reg <= 2'h0;
        end else if (intr_done && !cnt_done &&
                     ((state_reg == ppcs_pkg::ST_COUNT) ||
                      ((state_reg == ppcs_pkg::ST_APP) &&
                       ((smode != ppcs_pkg::SMODE_RST_FIRST) || rst_seen_reg)))) begin
            count_reg <= count_reg + 2'h1;
        end
    end

    // Window time at rest; starts as the press stops at top
    always_ff @(posedge sys_clk) begin
        if (reset || (state_next == ppcs_pkg::ST_COUNT && state_reg != ppcs_pkg::ST_COUNT)) begin
            win_cnt_reg <= 16'h0000;
        end else if (ms_tick && (state_reg == ppcs_pkg::ST_COUNT) &&
                     (win_cnt_reg != 16'hFFFF)) begin
            win_cnt_reg <= win_cnt_reg + 16'h0001;
        end
    end

    // Start bookkeeping flags
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rst_seen_reg <= 1'b0;
            first_done_reg <= 1'b0;
        end else begin
            if (state_reg != ppcs_pkg::ST_APP || ovr_bad) begin
                rst_seen_reg <= 1'b0;
            end else if (rbtn_rise) begin
                rst_seen_reg <= 1'b1;
            end
            if (state_next == ppcs_pkg::ST_APP && state_reg != ppcs_pkg::ST_APP) begin
                first_done_reg <= 1'b0;
            end else if (state_next == ppcs_pkg::ST_RUN) begin
                first_done_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                ppcs_pkg::ADDR_CTRL: reg_rdata <= {26'h0, ctrl_reg};
                ppcs_pkg::ADDR_WIN_MS: reg_rdata <= {16'h0, win_ms_reg};
                ppcs_pkg::ADDR_STATUS: begin
                    reg_rdata <= {24'h0, field_clear_s, safety_switch_output,
                                  count_reg, phase, state_reg};
                end
                ppcs_pkg::ADDR_IRQ_STAT: reg_rdata <= {27'h0, irq_stat_reg};
                ppcs_pkg::ADDR_IRQ_MASK: reg_rdata <= {27'h0, irq_mask_reg};
                default: reg_rdata <= 32'h00000000; // Unmapped reads zero
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_tdc_stop_off: assert property (
        (state_reg == ppcs_pkg::ST_RUN) && tdc_rise &&
        !(occupied && phase == ppcs_pkg::PH_DOWN)
        |=> !safety_switch_output && (state_reg == ppcs_pkg::ST_COUNT))
        else $error("outputs not off at top");

    a_down_cut: assert property (
        (state_reg == ppcs_pkg::ST_RUN) && occupied && !bdc_s && safety_switch_output
        |=> !safety_switch_output)
        else $error("downward break did not cut outputs");

    a_break_hold: assert property (
        intr_done |-> !$past(field_clear_s) && ($past(occ_ms_reg, 1) >= ppcs_pkg::OCC_MIN - 7'h01))
        else $error("break accepted too short");

    a_release_fast: assert property (
        (state_reg == ppcs_pkg::ST_COUNT) && !ovr_bad && intr_done &&
        (count_reg == need - 2'h1) |-> ##[1:2] safety_switch_output)
        else $error("outputs not re-closed after last break");

    a_double_wait: assert property (
        (state_reg == ppcs_pkg::ST_COUNT) && dbl && (count_reg == 2'h0) && intr_done &&
        !ovr_bad && !win_exp
        |=> !safety_switch_output && (count_reg == 2'h1))
        else $error("double mode released after one break");

    a_count_clear: assert property (
        (state_reg != ppcs_pkg::ST_COUNT) ##1 (state_reg == ppcs_pkg::ST_COUNT)
        |-> (count_reg == 2'h0) && (win_cnt_reg == 16'h0000))
        else $error("count or window not cleared at top");

    a_win_expire: assert property (
        (state_reg == ppcs_pkg::ST_COUNT) && win_exp && !ovr_bad &&
        !(intr_done && count_reg == need - 2'h1)
        |=> (state_reg == ppcs_pkg::ST_APP) [*2] ##0 !safety_switch_output)
        else $error("window expiry did not hold outputs off");

    a_overrun_stop: assert property (
        ovr_bad && (state_reg != ppcs_pkg::ST_APP) |=> (state_reg == ppcs_pkg::ST_APP))
        else $error("overrun contact low not handled");

    a_arm_holds: assert property (
        (state_reg == ppcs_pkg::ST_ARM) && !sbtn_rise |=> !safety_switch_output)
        else $error("outputs closed without start command");
endmodule // ppcs_seq
`default_nettype wire

/* verif/ppcs_press_model.sv */
// Press cam contacts and light curtain model
`timescale 1ns/1ps
`default_nettype none
module ppcs_press_model #(
    parameter int HALF = 200, // Cycles per half stroke
    parameter int TOPW = 20   // Half width of the top window
) (
    // Clock
    input wire logic sys_clk,
    // Drive and operator
    input wire logic safety_switch_output,
    input wire logic operator_in,
    input wire logic overrun_fault,
    // Contacts and sensor
    output logic tdc_contact,
    output logic bdc_contact,
    output logic overrun_contact,
    output logic protective_field_sensor
);
    // Crank angle in cycles, resting at top
    int angle = 2 * HALF - TOPW;
    // ------------------------------------------------------------
    // Crank
    // ------------------------------------------------------------
    // Moves only while outputs are closed; stops dead otherwise
    always_ff @(posedge sys_clk) begin
        if (safety_switch_output) begin
            angle <= (angle + 1) % (2 * HALF);
        end
    end
    // Top and bottom windows never overlap
    assign tdc_contact = (angle >= 2 * HALF - TOPW) || (angle < TOPW);
    assign bdc_contact = (angle >= HALF) && (angle < 2 * HALF - TOPW);
    // Overrun cam stays made unless the bench injects a fault
    assign overrun_contact = !overrun_fault;
    // Field clear unless the operator reaches in
    assign protective_field_sensor = !operator_in;
endmodule // ppcs_press_model
`default_nettype wire

/* verif/test_press_presence_sensing_cycle_start_cycle_sequencer.sv */
// Self-checking bench for the press cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module test_press_presence_sensing_cycle_start_cycle_sequencer;
    // Short tick keeps 100 ms breaks at 1000 cycles
    localparam int MS = 10;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic op = 1'b0; // Operator hand in the field
    logic rst_btn = 1'b0;
    logic start_btn = 1'b0;
    logic ovr_f = 1'b0; // Overrun cam fault
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [31:0] got;
    logic out, irq, tdc, bdc, ovr, fld;
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    // Ordinary cases: address beside its value after reset
    logic [7:0] row_a [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    logic [31:0] row_e [6] = '{32'h0, 32'h3E8, 32'h80, 32'h0, 32'h0, 32'h0};

    always #25 sys_clk = ~sys_clk;

    ppcs_seq #(.CYC_PER_MS(MS)) ppcs_seq_inst (.sys_clk(sys_clk), .reset(reset),
        .tdc_contact(tdc), .bdc_contact(bdc), .overrun_contact(ovr),
        .protective_field_sensor(fld), .reset_button(rst_btn), .start_button(start_btn),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdata), .safety_switch_output(out), .irq(irq));
    ppcs_press_model ppcs_press_model_inst (.sys_clk(sys_clk),
        .safety_switch_output(out), .operator_in(op), .overrun_fault(ovr_f), .tdc_contact(tdc),
        .bdc_contact(bdc), .overrun_contact(ovr), .protective_field_sensor(fld));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
        #1;
    endtask
    // Data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Bounded wait for the outputs to reach a level
    task automatic wait_out(input logic v, input int lim);
        for (int i = 0; i < lim && out !== v; i++) begin
            @(posedge sys_clk);
            #1;
        end
        chk("safety output", {31'h0, v}, {31'h0, out});
    endtask
    // Operator holds the field occupied for ms, then leaves
    task automatic brk(input int ms);
        @(posedge sys_clk);
        op <= 1'b1;
        tick(ms * MS);
        op <= 1'b0;
    endtask
    task automatic press_reset();
        @(posedge sys_clk);
        rst_btn <= 1'b1;
        tick(5);
        rst_btn <= 1'b0;
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Hang guard, well above the expected 20200 cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            bad_count++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        tick(16);
        reset <= 1'b0;
        tick(4);
        foreach (row_a[i]) begin
            rd_reg(row_a[i]);
            chk("register", row_e[i], got);
        end
        $display("reset values done");
        // Reset-first start: button, then one break
        wr_reg(ppcs_pkg::ADDR_CTRL, 32'h4);
        press_reset();
        brk(120);
        wait_out(1'b1, 2000);
        wait_out(1'b0, 600);
        brk(50);
        tick(2500);
        chk("short break", 32'h0, {31'h0, out});
        brk(120);
        wait_out(1'b1, 2000);
        $display("single break done");
        // Double break mode
        wr_reg(ppcs_pkg::ADDR_CTRL, 32'h1);
        wait_out(1'b0, 600);
        brk(120);
        tick(2500);
        chk("first of two", 32'h0, {31'h0, out});
        brk(120);
        wait_out(1'b1, 2000);
        $display("double break done");
        // Window of 50 ms runs out before the breaks
        wr_reg(ppcs_pkg::ADDR_WIN_MS, 32'd50);
        wr_reg(ppcs_pkg::ADDR_CTRL, 32'h3);
        wait_out(1'b0, 600);
        tick(600);
        brk(120);
        brk(120);
        tick(100);
        chk("late breaks", 32'h0, {31'h0, out});
        rd_reg(ppcs_pkg::ADDR_IRQ_STAT);
        chk("expired flag", 32'h8, got & 32'h8);
        wr_reg(ppcs_pkg::ADDR_IRQ_MASK, 32'h8);
        chk("irq raised", 32'h1, {31'h0, irq});
        wr_reg(ppcs_pkg::ADDR_IRQ_STAT, 32'h8);
        chk("irq cleared", 32'h0, {31'h0, irq});
        // Standard start: break, then reset button
        wr_reg(ppcs_pkg::ADDR_CTRL, 32'h0);
        brk(120);
        tick(100);
        chk("before button", 32'h0, {31'h0, out});
        press_reset();
        wait_out(1'b1, 100);
        $display("window done");
        // Break in the downward stroke
        for (int i = 0; i < 100 && tdc !== 1'b0; i++) @(posedge sys_clk);
        tick(10);
        rd_reg(ppcs_pkg::ADDR_STATUS);
        chk("phase", 32'h4, got & 32'hC);
        op <= 1'b1;
        wait_out(1'b0, 10);
        rd_reg(ppcs_pkg::ADDR_IRQ_STAT);
        chk("cut flag", 32'h4, got & 32'h4);
        op <= 1'b0;
        // No internal interlock: breaks alone restart
        wr_reg(ppcs_pkg::ADDR_CTRL, 32'h8);
        brk(120);
        wait_out(1'b1, 2000);
        $display("downward cut done");
        // Overrun contact drops while stopped at top
        wr_reg(ppcs_pkg::ADDR_CTRL, 32'h28);
        wait_out(1'b0, 600);
        ovr_f <= 1'b1;
        tick(5);
        rd_reg(ppcs_pkg::ADDR_IRQ_STAT);
        chk("overrun flag", 32'h10, got & 32'h10);
        brk(120);
        tick(100);
        chk("overrun hold", 32'h0, {31'h0, out});
        $display("overrun done");
        // Start input defined: breaks, then start button once
        ovr_f <= 1'b0;
        wr_reg(ppcs_pkg::ADDR_CTRL, 32'h18);
        brk(120);
        tick(100);
        chk("before start", 32'h0, {31'h0, out});
        start_btn <= 1'b1;
        tick(5);
        start_btn <= 1'b0;
        wait_out(1'b1, 100);
        $display("start input done");
        finish_test();
    end
endmodule // test_press_presence_sensing_cycle_start_cycle_sequencer
`default_nettype wire
